// ==== shared/ssc_pkg.sv ====
// constants shared by both ends of the serial command link
// assumes a 250 MHz system clock on both ends
package ssc_pkg;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] SSC_BURST_READ_CMD  = 8'h81;
  localparam logic [7:0] SSC_BURST_WRITE_CMD = 8'h06;
  localparam logic [7:0] SSC_STATE_QUERY_CMD = 8'h0a;
  localparam logic [7:0] SSC_STATE_CLEAR_CMD = 8'h08;
  localparam logic [7:0] SSC_SETUP_READ_CMD  = 8'h02;
  localparam logic [7:0] SSC_SETUP_WRITE_CMD = 8'h04;
  // ----------------------------------------
  // serial_port_state bit positions
  // ----------------------------------------
  localparam int SSC_SETUP_OK_BIT      = 1;
  localparam int SSC_BUF_READY_BIT     = 2;
  localparam int SSC_READ_FAULT_BIT    = 3;
  localparam int SSC_WRITE_FAULT_BIT   = 4;
  localparam int SSC_DONE_BIT          = 5;
  localparam int SSC_TIMEOUT_BIT       = 6;
  localparam int SSC_BAD_CMD_BIT       = 7;
  localparam logic [7:0] SSC_STATE_RESET = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SSC_CLK_MHZ           = 250;
  localparam int SSC_TIMEOUT_NS_X100   = 3175000;
  localparam int SSC_TIMEOUT_CYCLES    = (SSC_TIMEOUT_NS_X100 / 100) * SSC_CLK_MHZ / 1000;
  localparam int SSC_SCK_MAX_KHZ       = 2000;
  localparam int SSC_SCK_HALF_CYCLES   = (SSC_CLK_MHZ * 1000 + 2 * SSC_SCK_MAX_KHZ - 1)
                                         / (2 * SSC_SCK_MAX_KHZ);
  localparam int SSC_GAP_NS            = 1000;
  localparam int SSC_GAP_CYCLES        = (SSC_GAP_NS * SSC_CLK_MHZ + 999) / 1000;
  localparam int SSC_MEM_BYTES         = 256;
  // ----------------------------------------
  // host order register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] SSC_H_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SSC_H_LEN_OFS    = 8'h04;
  localparam logic [7:0] SSC_H_TXDATA_OFS = 8'h08;
  localparam logic [7:0] SSC_H_STATUS_OFS = 8'h0c;
  localparam logic [7:0] SSC_H_RXDATA_OFS = 8'h10;
  localparam logic [31:0] SSC_H_ZERO      = 32'h0000_0000;
endpackage : ssc_pkg

// ==== shared/ssc_link_if.sv ====
// serial link between host master end and device slave end
// assumes the bench supplies hclk and hresetn of both ends
`timescale 1ns/100ps
`default_nettype none
interface ssc_link_if;
  logic sck;
  logic chip_select_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport host (output sck, output chip_select_low, output mosi, input miso);
  modport dev  (input sck, input chip_select_low, input mosi, output miso, output miso_oe);
endinterface : ssc_link_if
`default_nettype wire

// ==== hdl/ssc_device.sv ====
// device end: serial slave command decoder, memory and state register
// assumes link pins are asynchronous to hclk and the master keeps sck low at idle
//
// Summary of operation
// - chip select falling edge starts frame
// - first byte of frame is command
// - master changes mosi while sck low
// - device shifts out on falling edge
// - bytes go least significant bit first
// - setup read takes address and length
// - setup write takes address and length
// - burst read sends, burst write accepts
// - state query returns state byte
// - state clear byte clears fault flags
// - bit 1 shows setup succeeded
// - bit 2 ready, cleared by new setup
// - bit 3 read fault, sticky
// - bit 4 write fault, sticky
// - bit 5 done, cleared by new setup
// - bit 6 idle timeout, sticky
// - bit 7 bad command, cleared by good
// - master polls state each step
// - master clears fault then polls zero
// - serial clock at most 2 MHz
// - only selected port is active
`timescale 1ns/100ps
`default_nettype none
module ssc_device
  import ssc_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   port_select_spi,
  ssc_link_if.dev     link,
  output logic [7:0]  state_out,
  output logic [15:0] mem_addr_out
);
  // ----------------------------------------
  // types and state
  // ----------------------------------------
  typedef enum logic [3:0] {
    SSC_IDLE = 4'b0001, SSC_CMD = 4'b0010, SSC_ARG = 4'b0100, SSC_DATA = 4'b1000
  } ssc_dev_e;
  ssc_dev_e    st_reg, st_next;
  logic [2:0]  sck_sync_reg, cs_sync_reg, mosi_sync_reg;
  logic [2:0]  sck_sync_next, cs_sync_next, mosi_sync_next;
  logic        sel_reg, sel_next, sel_done_reg, sel_done_next;
  logic [1:0]  ps_sync_reg, ps_sync_next, sel_wait_reg, sel_wait_next;
  logic [7:0]  rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
  logic [2:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [1:0]  arg_cnt_reg, arg_cnt_next;
  logic [15:0] addr_reg, addr_next, len_reg, len_next;
  logic [15:0] cur_reg, cur_next, left_reg, left_next;
  logic        cfg_rd_reg, cfg_rd_next, cfg_wr_reg, cfg_wr_next;
  logic        bad_burst_reg, bad_burst_next;
  logic [7:0]  state_reg, state_next;
  logic        miso_reg, miso_next;
  logic [31:0] idle_cnt_reg, idle_cnt_next;
  logic [7:0]  mem [SSC_MEM_BYTES];
  logic        mem_we;
  logic        sck_rise, sck_fall, cs_fall, cs_rise, cs_act, rxd;
  logic [7:0]  byte_in;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic valid_cmd(input logic [7:0] c);
    valid_cmd = (c == SSC_BURST_READ_CMD) || (c == SSC_BURST_WRITE_CMD) ||
                (c == SSC_STATE_QUERY_CMD) || (c == SSC_STATE_CLEAR_CMD) ||
                (c == SSC_SETUP_READ_CMD) || (c == SSC_SETUP_WRITE_CMD);
  endfunction : valid_cmd
  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign cs_fall  = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign cs_rise  = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign cs_act   = ~cs_sync_reg[1] & sel_reg;
  assign rxd      = mosi_sync_reg[1];
  assign byte_in  = {rxd, rx_sh_reg[7:1]};
  assign link.miso    = miso_reg;
  assign link.miso_oe = cs_act;
  assign state_out    = state_reg;
  assign mem_addr_out = cur_reg;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    sck_sync_next  = {sck_sync_reg[1:0], link.sck};
    cs_sync_next   = {cs_sync_reg[1:0], link.chip_select_low};
    mosi_sync_next = {mosi_sync_reg[1:0], link.mosi};
    ps_sync_next   = {ps_sync_reg[0], port_select_spi};
    sel_wait_next  = {sel_wait_reg[0], 1'b1};
    sel_next       = sel_reg;
    sel_done_next  = sel_done_reg | sel_wait_reg[1];
    if (!sel_done_reg && sel_wait_reg[1]) begin
      sel_next = ps_sync_reg[1];
    end
    st_next        = st_reg;
    rx_sh_next     = rx_sh_reg;
    tx_sh_next     = tx_sh_reg;
    bit_cnt_next   = bit_cnt_reg;
    cmd_next       = cmd_reg;
    arg_cnt_next   = arg_cnt_reg;
    addr_next      = addr_reg;
    len_next       = len_reg;
    cur_next       = cur_reg;
    left_next      = left_reg;
    cfg_rd_next    = cfg_rd_reg;
    cfg_wr_next    = cfg_wr_reg;
    bad_burst_next = bad_burst_reg;
    state_next     = state_reg;
    miso_next      = miso_reg;
    mem_we         = 1'b0;
    idle_cnt_next  = idle_cnt_reg;
    // idle timeout during an open transfer
    if (st_reg == SSC_ARG || st_reg == SSC_DATA) begin
      if (sck_rise || sck_fall) begin
        idle_cnt_next = '0;
      end else if (idle_cnt_reg >= 32'(SSC_TIMEOUT_CYCLES)) begin
        state_next[SSC_TIMEOUT_BIT] = 1'b1;
      end else begin
        idle_cnt_next = idle_cnt_reg + 32'd1;
      end
    end else begin
      idle_cnt_next = '0;
    end
    if (cs_fall && sel_reg) begin
      st_next      = SSC_CMD;
      bit_cnt_next = '0;
      tx_sh_next   = state_reg;
    end else if (!cs_act) begin
      st_next = SSC_IDLE;
    end else begin
      if (sck_fall) begin
        miso_next  = tx_sh_reg[0];
        tx_sh_next = {1'b0, tx_sh_reg[7:1]};
      end
      if (sck_rise) begin
        rx_sh_next   = byte_in;
        bit_cnt_next = bit_cnt_reg + 3'd1;
        if (bit_cnt_reg == 3'd7) begin
          unique case (st_reg)
            SSC_CMD: begin
              cmd_next     = byte_in;
              arg_cnt_next = '0;
              st_next      = SSC_ARG;
              if (!valid_cmd(byte_in)) begin
                state_next[SSC_BAD_CMD_BIT] = 1'b1;
                st_next = SSC_IDLE;
              end else begin
                state_next[SSC_BAD_CMD_BIT] = 1'b0;
                if (byte_in == SSC_SETUP_READ_CMD || byte_in == SSC_SETUP_WRITE_CMD) begin
                  state_next[SSC_BUF_READY_BIT] = 1'b0;
                  state_next[SSC_DONE_BIT]      = 1'b0;
                  state_next[SSC_SETUP_OK_BIT]  = 1'b0;
                  cfg_rd_next = 1'b0;
                  cfg_wr_next = 1'b0;
                end
                if (byte_in == SSC_STATE_QUERY_CMD) begin
                  tx_sh_next = state_reg;
                end
                if (byte_in == SSC_BURST_READ_CMD) begin
                  bad_burst_next = ~cfg_rd_reg;
                  cur_next       = addr_reg;
                  left_next      = len_reg;
                  tx_sh_next     = mem[addr_reg[7:0]];
                  if (!cfg_rd_reg) begin
                    state_next[SSC_READ_FAULT_BIT] = 1'b1;
                  end
                end
                if (byte_in == SSC_BURST_WRITE_CMD) begin
                  bad_burst_next = ~cfg_wr_reg;
                  cur_next       = addr_reg;
                  left_next      = len_reg;
                  if (!cfg_wr_reg) begin
                    state_next[SSC_WRITE_FAULT_BIT] = 1'b1;
                  end
                end
              end
            end
            SSC_ARG: begin
              if (cmd_reg == SSC_SETUP_READ_CMD || cmd_reg == SSC_SETUP_WRITE_CMD) begin
                arg_cnt_next = arg_cnt_reg + 2'd1;
                unique case (arg_cnt_reg)
                  2'd0: addr_next[7:0]  = byte_in;
                  2'd1: addr_next[15:8] = byte_in;
                  2'd2: len_next[7:0]   = byte_in;
                  2'd3: begin
                    len_next[15:8] = byte_in;
                    cfg_rd_next = (cmd_reg == SSC_SETUP_READ_CMD);
                    cfg_wr_next = (cmd_reg == SSC_SETUP_WRITE_CMD);
                    state_next[SSC_SETUP_OK_BIT]  = 1'b1;
                    state_next[SSC_BUF_READY_BIT] = 1'b1;
                    st_next = SSC_IDLE;
                  end
                endcase
              end else if (cmd_reg == SSC_STATE_CLEAR_CMD) begin
                state_next[SSC_READ_FAULT_BIT]  = 1'b0;
                state_next[SSC_WRITE_FAULT_BIT] = 1'b0;
                state_next[SSC_TIMEOUT_BIT]     = 1'b0;
                st_next = SSC_IDLE;
              end else if (cmd_reg == SSC_BURST_READ_CMD ||
                           cmd_reg == SSC_BURST_WRITE_CMD) begin
                st_next = SSC_DATA;
              end else begin
                st_next = SSC_IDLE;
              end
            end
            default: begin
            end
          endcase
          if (st_reg == SSC_DATA || (st_reg == SSC_ARG &&
              (cmd_reg == SSC_BURST_READ_CMD || cmd_reg == SSC_BURST_WRITE_CMD))) begin
            if (!bad_burst_reg && left_reg != 16'd0) begin
              mem_we    = (cmd_reg == SSC_BURST_WRITE_CMD);
              cur_next  = cur_reg + 16'd1;
              left_next = left_reg - 16'd1;
              tx_sh_next = mem[8'(cur_reg + 16'd1)];
              if (left_reg == 16'd1) begin
                state_next[SSC_DONE_BIT]      = 1'b1;
                state_next[SSC_BUF_READY_BIT] = 1'b0;
                cfg_rd_next = 1'b0;
                cfg_wr_next = 1'b0;
              end
            end
          end
        end
      end
    end
    // frame closed early during a burst
    if (cs_rise && st_reg == SSC_DATA && !bad_burst_reg && left_reg != 16'd0) begin
      if (cmd_reg == SSC_BURST_READ_CMD) begin
        state_next[SSC_READ_FAULT_BIT] = 1'b1;
      end else begin
        state_next[SSC_WRITE_FAULT_BIT] = 1'b1;
      end
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= SSC_IDLE;
      sck_sync_reg <= '0;
      cs_sync_reg <= 3'b111;
      mosi_sync_reg <= '0;
      sel_reg <= 1'b0;
      sel_done_reg <= 1'b0;
      ps_sync_reg <= '0;
      sel_wait_reg <= '0;
      rx_sh_reg <= '0;
      tx_sh_reg <= '0;
      bit_cnt_reg <= '0;
      cmd_reg <= '0;
      arg_cnt_reg <= '0;
      addr_reg <= '0;
      len_reg <= '0;
      cur_reg <= '0;
      left_reg <= '0;
      cfg_rd_reg <= 1'b0;
      cfg_wr_reg <= 1'b0;
      bad_burst_reg <= 1'b0;
      state_reg <= SSC_STATE_RESET;
      miso_reg <= 1'b0;
      idle_cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      sck_sync_reg <= sck_sync_next;
      cs_sync_reg <= cs_sync_next;
      mosi_sync_reg <= mosi_sync_next;
      sel_reg <= sel_next;
      sel_done_reg <= sel_done_next;
      ps_sync_reg <= ps_sync_next;
      sel_wait_reg <= sel_wait_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      bit_cnt_reg <= bit_cnt_next;
      cmd_reg <= cmd_next;
      arg_cnt_reg <= arg_cnt_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      cur_reg <= cur_next;
      left_reg <= left_next;
      cfg_rd_reg <= cfg_rd_next;
      cfg_wr_reg <= cfg_wr_next;
      bad_burst_reg <= bad_burst_next;
      state_reg <= state_next;
      miso_reg <= miso_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[cur_reg[7:0]] <= byte_in;
    end
  end
endmodule : ssc_device
`default_nettype wire

// ==== hdl/ssc_host.sv ====
// host end: ahb-lite slave taking byte orders, drives the serial master
// assumes ahb-lite single word transfers; device end on the same link
`timescale 1ns/100ps
`default_nettype none
module ssc_host
  import ssc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  ssc_link_if.host         link
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    SSC_H_IDLE = 4'b0001, SSC_H_LOW = 4'b0010, SSC_H_HIGH = 4'b0100, SSC_H_GAP = 4'b1000
  } ssc_host_e;
  ssc_host_e   st_reg, st_next;
  logic [1:0]  miso_sync_reg, miso_sync_next;
  logic        wr_ph_reg, wr_ph_next;
  logic [7:0]  adr_reg, adr_next;
  logic [7:0]  tx_reg, tx_next, rx_reg, rx_next, sh_reg, sh_next;
  logic [7:0]  rxd_reg, rxd_next;
  logic        go_reg, go_next, last_reg, last_next, busy_reg, busy_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  div_reg, div_next;
  logic        sck_reg, sck_next, cs_reg, cs_next, mosi_reg, mosi_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        addr_ph;
  assign addr_ph   = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign link.sck  = sck_reg;
  assign link.chip_select_low = cs_reg;
  assign link.mosi = mosi_reg;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    miso_sync_next = {miso_sync_reg[0], link.miso};
    wr_ph_next = addr_ph & hwrite;
    adr_next   = addr_ph ? haddr[7:0] : adr_reg;
    tx_next    = tx_reg;
    go_next    = go_reg;
    last_next  = last_reg;
    rdata_next = rdata_reg;
    if (addr_ph && !hwrite) begin
      rdata_next = SSC_H_ZERO;
      if (haddr[7:0] == SSC_H_STATUS_OFS) begin
        rdata_next = {31'd0, busy_reg};
      end else if (haddr[7:0] == SSC_H_RXDATA_OFS) begin
        rdata_next = {24'd0, rxd_reg};
      end
    end
    if (wr_ph_reg && adr_reg == SSC_H_TXDATA_OFS && !busy_reg) begin
      tx_next   = hwdata[7:0];
      last_next = hwdata[8]; // close frame after this byte
      go_next   = 1'b1;
    end
    st_next = st_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    rxd_next = rxd_reg;
    sck_next = sck_reg;
    cs_next = cs_reg;
    mosi_next = mosi_reg;
    busy_next = busy_reg | go_next;
    unique case (st_reg)
      SSC_H_IDLE: begin
        if (go_reg) begin
          go_next  = 1'b0;
          cs_next  = 1'b0;
          sh_next  = tx_reg;
          mosi_next = tx_reg[0];
          bit_next = '0;
          div_next = 8'(SSC_GAP_CYCLES);
          st_next  = SSC_H_LOW;
        end
      end
      SSC_H_LOW: begin
        mosi_next = sh_reg[0];
        if (div_reg != 8'd0) begin
          div_next = div_reg - 8'd1;
        end else begin
          sck_next = 1'b1;
          div_next = 8'(SSC_SCK_HALF_CYCLES);
          st_next  = SSC_H_HIGH;
        end
      end
      SSC_H_HIGH: begin
        if (div_reg != 8'd0) begin
          div_next = div_reg - 8'd1;
        end else begin
          sck_next = 1'b0;
          rx_next  = {miso_sync_reg[1], rx_reg[7:1]};
          div_next = 8'(SSC_SCK_HALF_CYCLES);
          bit_next = bit_reg + 3'd1;
          sh_next  = {1'b0, sh_reg[7:1]};
          st_next  = SSC_H_LOW;
          if (bit_reg == 3'd7) begin
            rxd_next = {miso_sync_reg[1], rx_reg[7:1]};
            div_next = 8'(SSC_GAP_CYCLES);
            st_next  = SSC_H_GAP;
          end
        end
      end
      SSC_H_GAP: begin
        if (div_reg != 8'd0) begin
          div_next = div_reg - 8'd1;
        end else begin
          cs_next   = last_reg ? 1'b1 : cs_reg;
          busy_next = 1'b0;
          st_next   = SSC_H_IDLE;
        end
      end
      default: begin
        st_next = SSC_H_IDLE;
      end
    endcase
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= SSC_H_IDLE;
      miso_sync_reg <= '0;
      wr_ph_reg <= 1'b0;
      adr_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      sh_reg <= '0;
      rxd_reg <= '0;
      go_reg <= 1'b0;
      last_reg <= 1'b0;
      busy_reg <= 1'b0;
      bit_reg <= '0;
      div_reg <= '0;
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
      mosi_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      miso_sync_reg <= miso_sync_next;
      wr_ph_reg <= wr_ph_next;
      adr_reg <= adr_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      sh_reg <= sh_next;
      rxd_reg <= rxd_next;
      go_reg <= go_next;
      last_reg <= last_next;
      busy_reg <= busy_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      cs_reg <= cs_next;
      mosi_reg <= mosi_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : ssc_host
`default_nettype wire

// ==== test/ssc_link_sva.sv ====
// checker for the serial link between the host end and the device end
// assumes the signals of ssc_link_if, all sampled in the hclk domain
`timescale 1ns/100ps
`default_nettype none
module ssc_link_sva
  import ssc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sck,
  input wire logic chip_select_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  localparam int HALF_MIN = SSC_SCK_HALF_CYCLES - 2;
  logic        sck_d_reg, sck_d_next;
  logic [15:0] half_reg, half_next;
  logic [2:0]  bits_reg, bits_next;
  always_comb begin
    sck_d_next = sck;
    half_next  = (sck != sck_d_reg) ? 16'h0000 : half_reg + ((&half_reg) ? 16'h0000 : 16'h0001);
    bits_next  = chip_select_low ? 3'h0 : bits_reg + {2'h0, sck & ~sck_d_reg};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_d_reg <= 1'b0;
      half_reg  <= 16'h0000;
      bits_reg  <= 3'h0;
    end else begin
      sck_d_reg <= sck_d_next;
      half_reg  <= half_next;
      bits_reg  <= bits_next;
    end
  end
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_open;
    $fell(chip_select_low);
  endsequence
  a_idle_clk_low: assert property (chip_select_low |-> !sck)
    else $error("serial clock high outside a frame");
  a_open_quiet: assert property (s_open |-> !sck [*8])
    else $error("serial clock moved right at frame start");
  a_open_drive: assert property (s_open |-> ##[0:4] miso_oe)
    else $error("device did not drive its output in a frame");
  a_oe_release: assert property (chip_select_low [*4] |-> !miso_oe)
    else $error("device drives its output while deselected");
  a_mosi_clk_low: assert property ($changed(mosi) && !chip_select_low |-> !sck && !$past(sck))
    else $error("host data moved while serial clock high");
  a_miso_clk_low: assert property (miso_oe && $changed(miso) |-> !sck)
    else $error("device data moved while serial clock high");
  a_sck_rate: assert property ((sck != sck_d_reg) && !chip_select_low |-> half_reg >= HALF_MIN)
    else $error("serial clock half period too short");
  a_whole_bytes: assert property ($rose(chip_select_low) |-> bits_reg == 3'h0)
    else $error("frame ended in mid byte");
endmodule : ssc_link_sva
`default_nettype wire

// ==== test/ssc_link_tb.sv ====
// testbench: ahb-lite master drives the host end, the device end answers on the link
// assumes both ends share hclk and hresetn
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) comparisons++; if ((g) !== (w)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, g, w); end
module ssc_link_tb
  import ssc_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  state_out;
  logic [15:0] mem_addr_out;
  logic [7:0]  rxq[$];
  int          errors = 0, comparisons = 0, cycles = 0;
  ssc_link_if link ();
  ssc_host i_ssc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
  ssc_device i_ssc_device (.hclk(hclk), .hresetn(hresetn), .port_select_spi(1'b1),
    .link(link), .state_out(state_out), .mem_addr_out(mem_addr_out));
  ssc_link_sva i_ssc_link_sva (.hclk(hclk), .hresetn(hresetn), .sck(link.sck),
    .chip_select_low(link.chip_select_low), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe));
  always #2 hclk = ~hclk;
  // ----------------------------------------
  // bus and link tasks
  // ----------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, ofs};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic frame(input logic [7:0] b[$]);
    logic [31:0] r;
    rxq = {};
    foreach (b[i]) begin
      ahb(1'b1, SSC_H_TXDATA_OFS, {23'h0, i == b.size() - 1, b[i]}, r);
      repeat (4) @(posedge hclk);
      do ahb(1'b0, SSC_H_STATUS_OFS, 32'h0, r); while (r[0] !== 1'b0);
      ahb(1'b0, SSC_H_RXDATA_OFS, 32'h0, r);
      rxq.push_back(r[7:0]);
    end
    repeat (8) @(posedge hclk);
  endtask : frame
  task automatic query(input logic [7:0] exp);
    frame('{SSC_STATE_QUERY_CMD, 8'h00});
    `CHK(rxq[1], exp)
  endtask : query
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write_burst();
    query(8'h00);
    frame('{SSC_SETUP_WRITE_CMD, 8'h10, 8'h00, 8'h02, 8'h00});
    `CHK(state_out, 8'h06)
    query(8'h06);
    frame('{SSC_BURST_WRITE_CMD, 8'ha5, 8'h3c});
    `CHK(state_out, 8'h22)
    `CHK(mem_addr_out, 16'h0012)
  endtask : t_write_burst
  task automatic t_read_burst();
    frame('{SSC_SETUP_READ_CMD, 8'h10, 8'h00, 8'h02, 8'h00});
    `CHK(state_out, 8'h06)
    frame('{SSC_BURST_READ_CMD, 8'h00, 8'h00});
    `CHK(rxq[1], 8'ha5)
    `CHK(rxq[2], 8'h3c)
    query(8'h22);
  endtask : t_read_burst
  task automatic t_faults();
    frame('{8'h55});
    `CHK(state_out, 8'ha2)
    frame('{SSC_BURST_READ_CMD, 8'h00});
    `CHK(state_out, 8'h2a)
    frame('{SSC_BURST_WRITE_CMD, 8'h00});
    `CHK(state_out, 8'h3a)
    frame('{SSC_STATE_CLEAR_CMD, 8'h00});
    `CHK(state_out, 8'h22)
    query(8'h22);
  endtask : t_faults
  task automatic t_timeout();
    logic [31:0] r;
    ahb(1'b1, SSC_H_TXDATA_OFS, {24'h0, SSC_SETUP_READ_CMD}, r);
    repeat (SSC_TIMEOUT_CYCLES + 3000) @(posedge hclk);
    `CHK(state_out[SSC_TIMEOUT_BIT], 1'b1)
    frame('{8'h00});
    frame('{SSC_STATE_CLEAR_CMD, 8'h00});
    `CHK(state_out[SSC_TIMEOUT_BIT], 1'b0)
  endtask : t_timeout
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    t_write_burst();
    t_read_burst();
    t_faults();
    t_timeout();
    conclude();
  end
endmodule : ssc_link_tb
`default_nettype wire
